// File: hdl/tdf_cfg.svh
// register indices, reset values and field limits of the text fetch block
`ifndef TDF_CFG_SVH
`define TDF_CFG_SVH

// ----------------------------------------------------------------
// register indices (host index port values)
// ----------------------------------------------------------------
`define TDF_NREG     38
`define TDF_IDX_HT   6'h00
`define TDF_IDX_HD   6'h01
`define TDF_IDX_HSP  6'h02
`define TDF_IDX_SW   6'h03
`define TDF_IDX_VT   6'h04
`define TDF_IDX_VTA  6'h05
`define TDF_IDX_VD   6'h06
`define TDF_IDX_VSP  6'h07
`define TDF_IDX_CVT  6'h09
`define TDF_IDX_DSH  6'h0C
`define TDF_IDX_DSL  6'h0D
`define TDF_IDX_CHG  6'h16
`define TDF_IDX_CVD  6'h17
`define TDF_IDX_RPL  6'h24

// ----------------------------------------------------------------
// reset values (frame defaults to 127 x 33 cells, 80 x 25 displayed)
// ----------------------------------------------------------------
`define TDF_RST_HT   8'h7E
`define TDF_RST_HD   8'h50
`define TDF_RST_HSP  8'h66
`define TDF_RST_SW   8'h49
`define TDF_RST_VT   8'h20
`define TDF_RST_VTA  8'h00
`define TDF_RST_VD   8'h19
`define TDF_RST_VSP  8'h1D
`define TDF_RST_CVT  8'h07
`define TDF_RST_DSH  8'h00
`define TDF_RST_DSL  8'h00
`define TDF_RST_CHG  8'h78
`define TDF_RST_CVD  8'h08
`define TDF_RST_RPL  8'h05

// ----------------------------------------------------------------
// field limits
// ----------------------------------------------------------------
`define TDF_CVT_32B  5'h10
`define TDF_CELL_PIX 4'h8
`define TDF_RDY_BIT  7

`endif

// File: hdl/tdf_pkg.sv
// types shared by the text fetch block
package tdf_pkg;
`include "tdf_cfg.svh"

    // whole register file, one byte per index
    typedef logic [`TDF_NREG-1:0][7:0] tdf_regfile_t;

    // fetch sequencer states
    typedef enum logic [2:0] {
        TDF_CELL, TDF_CODE_REQ, TDF_CODE_WAIT, TDF_DEF_REQ, TDF_DEF_WAIT, TDF_PUSH
    } tdf_state_t;

    // register port state
    typedef struct packed {
        logic [5:0]   idx;
        logic         rdy;
        logic [7:0]   rdata;
        tdf_regfile_t file;
    } tdf_regs_s_t;

    // two-entry buffer state
    typedef struct packed {
        logic [1:0][7:0] mem;
        logic            wp;
        logic            rp;
        logic [1:0]      cnt;
    } tdf_buf_s_t;

    // fetch engine state
    typedef struct packed {
        tdf_state_t  st;
        logic [7:0]  hcnt;
        logic [4:0]  scan;
        logic [7:0]  vrow;
        logic [4:0]  adj;
        logic        in_adj;
        logic [15:0] row_base;
        logic [7:0]  code;
        logic [7:0]  pat;
        logic [15:0] addr;
        logic        hs;
        logic        vs;
        logic        de;
    } tdf_top_s_t;
endpackage

// File: hdl/tdf_regs.sv
// indexed address/data register port with status ready bit
`timescale 1ns/1ps
`include "tdf_cfg.svh"
module tdf_regs import tdf_pkg::*; (
    // clock and reset
    input  wire logic   sys_clk,
    input  wire logic   rst_n,
    // host port
    input  wire logic       host_sel,
    input  wire logic       host_rs,
    input  wire logic       host_we,
    input  wire logic [7:0] host_wdata,
    output logic      [7:0] host_rdata,
    // register contents
    output tdf_regfile_t    regs
);
    tdf_regs_s_t q, d;  // state and next state

    // only documented indices hold storage, the rest read zero
    function automatic logic impl(input logic [5:0] i);
        unique case (i)
            `TDF_IDX_HT, `TDF_IDX_HD, `TDF_IDX_HSP, `TDF_IDX_SW, `TDF_IDX_VT,
            `TDF_IDX_VTA, `TDF_IDX_VD, `TDF_IDX_VSP, `TDF_IDX_CVT, `TDF_IDX_DSH,
            `TDF_IDX_DSL, `TDF_IDX_CHG, `TDF_IDX_CVD, `TDF_IDX_RPL: impl = 1'b1;
            default: impl = 1'b0;
        endcase
    endfunction

    // reset image of the file
    localparam tdf_regfile_t FILE_RST = {
        8'h0, `TDF_RST_RPL, 96'h0, `TDF_RST_CVD, `TDF_RST_CHG, 64'h0, `TDF_RST_DSL,
        `TDF_RST_DSH, 16'h0, `TDF_RST_CVT, 8'h0, `TDF_RST_VSP, `TDF_RST_VD,
        `TDF_RST_VTA, `TDF_RST_VT, `TDF_RST_SW, `TDF_RST_HSP, `TDF_RST_HD, `TDF_RST_HT};

    // index write drops ready for one cycle, data write needs ready
    always_comb begin
        d = q;
        d.rdy = 1'b1;
        if (host_sel && host_we && !host_rs) begin
            d.idx = host_wdata[5:0];
            d.rdy = 1'b0;
        end
        if (host_sel && host_we && host_rs && q.rdy && impl(q.idx)) begin
            d.file[q.idx] = host_wdata;
        end
        if (host_sel && !host_we) begin
            d.rdata = host_rs ? (impl(q.idx) ? q.file[q.idx] : 8'h00) : {q.rdy, 1'b0, q.idx};
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{idx: 6'h00, rdy: 1'b1, rdata: 8'h00, file: FILE_RST};
        end else begin
            q <= d;
        end
    end

    assign host_rdata = q.rdata;
    assign regs       = q.file;

    // index write shows not-ready then ready again
    property p_rdy;
        @(posedge sys_clk) disable iff (!rst_n)
        (host_sel && host_we && !host_rs) |=> !q.rdy ##1 (q.rdy || $past(host_sel && host_we && !host_rs));
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready bit sequence wrong");
endmodule // tdf_regs

// File: hdl/tdf_buf.sv
// two-entry buffer between fetch engine and pixel consumer
`timescale 1ns/1ps
module tdf_buf import tdf_pkg::*; (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // fill side
    input  wire logic       in_valid,
    output logic            in_ready,
    input  wire logic [7:0] in_data,
    // drain side
    output logic            out_valid,
    input  wire logic       out_ready,
    output logic      [7:0] out_data
);
    tdf_buf_s_t q, d;  // state and next state
    logic push, pop;   // accepted transfers

    assign in_ready  = (q.cnt != 2'd2);
    assign out_valid = (q.cnt != 2'd0);
    assign out_data  = q.mem[q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and count update
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp        = ~q.wp;
        end
        if (pop) begin
            d.rp = ~q.rp;
        end
        d.cnt = q.cnt + 2'(push) - 2'(pop);
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule // tdf_buf

// File: hdl/tdf_text_fetch.sv
// character-mode display address generator, top level
// What this block does
// - start address from registers twelve and thirteen
// - next cell right fetches address plus one
// - row below fetches address plus row width
// - display byte indexes one of 256 definitions
// - code zero selects first stored definition
// - definitions occupy sixteen or thirty-two bytes
// - eight pixels wide, up to 32 lines tall, fewer may show
// - cell size from registers 9, 22, 23
// - frame programmable, default 127 by 33, 80 by 25 displayed
// - frame includes retrace and non-visible regions
// - frame timing from the timing registers
// - 32 bytes when cell total field >= 16
`timescale 1ns/1ps
`include "tdf_cfg.svh"
module tdf_text_fetch import tdf_pkg::*; (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // host register port
    input  wire logic        host_sel,
    input  wire logic        host_rs,
    input  wire logic        host_we,
    input  wire logic [7:0]  host_wdata,
    output logic      [7:0]  host_rdata,
    // character set base
    input  wire logic [15:0] def_base,
    // video ram port
    output logic             ram_req_valid,
    input  wire logic        ram_req_ready,
    output logic      [15:0] ram_addr,
    input  wire logic        ram_rvalid,
    input  wire logic [7:0]  ram_rdata,
    // pattern stream
    output logic             pix_valid,
    input  wire logic        pix_ready,
    output logic      [7:0]  pix_data,
    // frame timing
    output logic             hsync,
    output logic             vsync,
    output logic             disp_en
);
    // ----------------------------------------------------------------
    // register file and field views
    // ----------------------------------------------------------------
    tdf_regfile_t rf;         // register contents
    logic [7:0]   ht;         // last character column
    logic [7:0]   hd;         // displayed columns
    logic [7:0]   hsp;        // hsync start column
    logic [3:0]   hw;         // hsync width in columns
    logic [3:0]   vw;         // vsync width in rows
    logic [7:0]   vt;         // last character row
    logic [4:0]   vta;        // extra scan lines per frame
    logic [7:0]   vd;         // displayed rows
    logic [7:0]   vsp;        // vsync start row
    logic [4:0]   cvt;        // last scan line of a cell
    logic [4:0]   cvd;        // displayed scan lines of a cell
    logic [3:0]   cdh;        // displayed pixels of a cell
    logic [15:0]  start;      // display start address

    tdf_regs u_regs (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .host_sel   (host_sel),
        .host_rs    (host_rs),
        .host_we    (host_we),
        .host_wdata (host_wdata),
        .host_rdata (host_rdata),
        .regs       (rf)
    );

    // field extraction from the timing and cell registers
    assign ht    = rf[`TDF_IDX_HT];
    assign hd    = rf[`TDF_IDX_HD];
    assign hsp   = rf[`TDF_IDX_HSP];
    assign hw    = rf[`TDF_IDX_SW][3:0];
    assign vw    = rf[`TDF_IDX_SW][7:4];
    assign vt    = rf[`TDF_IDX_VT];
    assign vta   = rf[`TDF_IDX_VTA][4:0];
    assign vd    = rf[`TDF_IDX_VD];
    assign vsp   = rf[`TDF_IDX_VSP];
    assign cvt   = rf[`TDF_IDX_CVT][4:0];
    assign cvd   = rf[`TDF_IDX_CVD][4:0];
    assign cdh   = rf[`TDF_IDX_CHG][3:0];
    assign start = {rf[`TDF_IDX_DSH], rf[`TDF_IDX_DSL]};

    // ----------------------------------------------------------------
    // fetch engine state
    // ----------------------------------------------------------------
    tdf_top_s_t  q, d;        // state and next state
    logic        vis;         // current cell lies in the visible area
    logic        step;        // advance to the next cell position
    logic        last_col;    // current column is the last of a line
    logic        last_scan;   // current scan line closes the cell row
    logic        frame_end;   // step closes the whole frame
    logic        row_end;     // step closes a character row
    logic        big;         // definitions use 32 bytes
    logic [15:0] def_off;     // code scaled by definition size
    logic [15:0] def_addr;    // address of the pattern byte
    logic [7:0]  mask;        // displayed pixel mask
    logic        buf_ready;   // buffer can take a pattern
    logic        buf_valid;   // pattern offered to the buffer

    // visible area: displayed columns, rows and scan lines only
    assign vis = (q.hcnt < hd) && (q.vrow < vd) && !q.in_adj && (q.scan < cvd);

    assign last_col  = (q.hcnt == ht);
    assign last_scan = (q.scan == cvt);

    // row closes on the last column of its last scan line
    assign row_end   = step && last_col && !q.in_adj && last_scan;

    // frame closes after the last row, or after the adjust lines
    assign frame_end = step && last_col &&
                       (q.in_adj ? (q.adj + 5'd1 >= vta) : (last_scan && q.vrow == vt && vta == 5'd0));

    // definition size follows the cell total field
    assign big = (cvt >= `TDF_CVT_32B);

    // screen code times 16 or 32, code zero lands on the base itself
    assign def_off  = big ? {3'h0, ram_rdata, 5'h00} : {4'h0, ram_rdata, 4'h0};
    assign def_addr = def_base + def_off + {11'h000, q.scan};

    // keep only the leftmost displayed pixels of the cell
    assign mask = (cdh >= `TDF_CELL_PIX) ? 8'hFF : ~(8'hFF >> cdh[2:0]);

    // ----------------------------------------------------------------
    // sequencer and frame counters
    // ----------------------------------------------------------------
    // one ram access at a time; blank cells take a single cycle each
    always_comb begin
        d             = q;
        step          = 1'b0;
        ram_req_valid = 1'b0;
        buf_valid     = 1'b0;
        unique case (q.st)
            // decide fetch or blank for this position
            TDF_CELL: begin
                if (vis) begin
                    d.addr = q.row_base + {8'h00, q.hcnt};
                    d.st   = TDF_CODE_REQ;
                end else begin
                    step = 1'b1;
                end
            end
            // offer the display byte address
            TDF_CODE_REQ: begin
                ram_req_valid = 1'b1;
                if (ram_req_ready) begin
                    d.st = TDF_CODE_WAIT;
                end
            end
            // screen code returns, form the pattern address
            TDF_CODE_WAIT: begin
                if (ram_rvalid) begin
                    d.code = ram_rdata;
                    d.addr = def_addr;
                    d.st   = TDF_DEF_REQ;
                end
            end
            // offer the definition byte address
            TDF_DEF_REQ: begin
                ram_req_valid = 1'b1;
                if (ram_req_ready) begin
                    d.st = TDF_DEF_WAIT;
                end
            end
            // pattern returns, trim to displayed width
            TDF_DEF_WAIT: begin
                if (ram_rvalid) begin
                    d.pat = ram_rdata & mask;
                    d.st  = TDF_PUSH;
                end
            end
            // hand over; a full buffer stalls the whole walk
            TDF_PUSH: begin
                buf_valid = 1'b1;
                if (buf_ready) begin
                    step = 1'b1;
                    d.st = TDF_CELL;
                end
            end
        endcase

        // column, scan, row and adjust counters
        if (step) begin
            d.hcnt = last_col ? 8'h00 : q.hcnt + 8'h01;
            if (last_col) begin
                if (q.in_adj) begin
                    d.adj = q.adj + 5'd1;
                end else if (last_scan) begin
                    d.scan     = 5'd0;
                    d.row_base = q.row_base + {8'h00, hd};
                    if (q.vrow == vt) begin
                        d.in_adj = 1'b1;
                        d.adj    = 5'd0;
                    end else begin
                        d.vrow = q.vrow + 8'h01;
                    end
                end else begin
                    d.scan = q.scan + 5'd1;
                end
            end
        end

        // frame restart reloads the start address
        if (frame_end) begin
            d.vrow     = 8'h00;
            d.scan     = 5'd0;
            d.adj      = 5'd0;
            d.in_adj   = 1'b0;
            d.row_base = start;
        end

        // sync and enable windows, one cycle behind the counters
        d.hs = ({1'b0, q.hcnt} >= {1'b0, hsp}) && ({1'b0, q.hcnt} < {1'b0, hsp} + {5'h00, hw});
        d.vs = ({1'b0, q.vrow} >= {1'b0, vsp}) && ({1'b0, q.vrow} < {1'b0, vsp} + {5'h00, vw});
        d.de = vis;
    end

    // state register; frame starts at the reset start address
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: TDF_CELL, hcnt: 8'h00, scan: 5'd0, vrow: 8'h00, adj: 5'd0,
                   in_adj: 1'b0, row_base: {`TDF_RST_DSH, `TDF_RST_DSL}, code: 8'h00,
                   pat: 8'h00, addr: 16'h0000, hs: 1'b0, vs: 1'b0, de: 1'b0};
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // output buffer and pins
    // ----------------------------------------------------------------
    // decouples the consumer so a stall drops no pattern
    tdf_buf u_buf (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (buf_valid),
        .in_ready  (buf_ready),
        .in_data   (q.pat),
        .out_valid (pix_valid),
        .out_ready (pix_ready),
        .out_data  (pix_data)
    );

    assign ram_addr = q.addr;
    assign hsync    = q.hs;
    assign vsync    = q.vs;
    assign disp_en  = q.de;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // frame restart loads the start pair
    property p_start;
        frame_end |=> q.row_base == $past(start) && q.vrow == 8'h00;
    endproperty
    a_start: assert property (p_start) else $error("start address not reloaded");

    // code fetch address is row base plus column
    property p_col;
        (q.st == TDF_CELL && vis) |=> q.st == TDF_CODE_REQ && q.addr == $past(q.row_base) + {8'h00, $past(q.hcnt)};
    endproperty
    a_col: assert property (p_col) else $error("column address wrong");

    // next row starts one displayed row further on
    property p_row;
        (row_end && !frame_end) |=> q.row_base == $past(q.row_base) + {8'h00, $past(hd)};
    endproperty
    a_row: assert property (p_row) else $error("row stride wrong");

    // pattern address from code, size and scan line
    property p_def;
        (q.st == TDF_CODE_WAIT && ram_rvalid) |=> q.st == TDF_DEF_REQ &&
            q.addr == $past(def_base) + ($past(big) ? 16'h0020 : 16'h0010) * {8'h00, q.code} + {11'h000, q.scan};
    endproperty
    a_def: assert property (p_def) else $error("definition address wrong");

    // no fetch outside displayed scan lines; judged at entry,
    // since the host may rewrite the geometry while a cell is in flight
    property p_vis;
        (q.st == TDF_CODE_REQ && $past(q.st) == TDF_CELL) |-> $past(q.scan < cvd && q.hcnt < hd);
    endproperty
    a_vis: assert property (p_vis) else $error("fetch outside visible area");

    // hidden pixels never reach the buffer
    property p_mask;
        ($past(q.st) == TDF_DEF_WAIT && q.st == TDF_PUSH) |-> (q.pat & ~$past(mask)) == 8'h00;
    endproperty
    a_mask: assert property (p_mask) else $error("hidden pixels leaked");

    // blank positions pass in one cycle
    property p_blank;
        (q.st == TDF_CELL && !vis && !last_col) |=> q.hcnt == $past(q.hcnt) + 8'h01;
    endproperty
    a_blank: assert property (p_blank) else $error("blank cell stalled");

    // hsync rises only at the programmed column; a rewrite of the
    // sync registers may open the window anywhere, so skip those
    property p_hs;
        ($rose(hsync) && $past(hsp) == $past(hsp, 2) && $past(hw) == $past(hw, 2)) |->
            $past(q.hcnt) == $past(hsp);
    endproperty
    a_hs: assert property (p_hs) else $error("hsync start wrong");

    // 16-byte definition layout while the cell total field is below 16
    property p_big;
        $past(q.st == TDF_CODE_WAIT && ram_rvalid && !big) |->
            q.addr[4:0] == $past(def_base[4:0]) + {q.code[0], 4'h0} + q.scan;
    endproperty
    a_big: assert property (p_big) else $error("16-byte layout wrong");

    // main scenarios
    property p_c_frame;
        frame_end;
    endproperty
    c_frame: cover property (p_c_frame);

    property p_c_stall;
        q.st == TDF_PUSH && !buf_ready;
    endproperty
    c_stall: cover property (p_c_stall);

    property p_c_big;
        q.st == TDF_DEF_REQ && big;
    endproperty
    c_big: cover property (p_c_big);

    property p_c_adj;
        q.in_adj && frame_end;
    endproperty
    c_adj: cover property (p_c_adj);
endmodule // tdf_text_fetch

// File: dv/tdf_ram_model.sv
// video ram model on the far side of the fetch engine
`timescale 1ns/1ps
module tdf_ram_model (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // pacing: high stretches both accept and answer
    input  wire logic        slow,
    // request side
    input  wire logic        ram_req_valid,
    output logic             ram_req_ready,
    input  wire logic [15:0] ram_addr,
    // answer side
    output logic             ram_rvalid,
    output logic      [7:0]  ram_rdata
);
    logic [1:0]  gap_q;  // cycles left before accepting
    logic [1:0]  lat_q;  // cycles left before answering
    logic        busy_q; // one request outstanding
    logic [15:0] addr_q; // address being served
    // each location holds its own low address byte
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {ram_req_ready, ram_rvalid, busy_q, gap_q, lat_q} <= '0;
            ram_rdata <= 8'h00;
            addr_q    <= 16'h0000;
        end else begin
            ram_req_ready <= 1'b0;
            ram_rvalid    <= 1'b0;
            // byte no longer valid: never leave the old value standing
            if (ram_rvalid)
                ram_rdata <= ~ram_rdata;
            if (ram_req_valid && ram_req_ready) begin
                busy_q <= 1'b1;
                addr_q <= ram_addr;
                lat_q  <= slow ? 2'h3 : 2'h0;
                gap_q  <= slow ? 2'h2 : 2'h0;
            end else if (busy_q) begin
                if (lat_q == 2'h0) begin
                    ram_rvalid <= 1'b1;
                    ram_rdata  <= addr_q[7:0];
                    busy_q     <= 1'b0;
                end else
                    lat_q <= lat_q - 2'h1;
            end else if (ram_req_valid) begin
                if (gap_q == 2'h0)
                    ram_req_ready <= 1'b1;
                else
                    gap_q <= gap_q - 2'h1;
            end
        end
    end
endmodule // tdf_ram_model

// File: dv/text_display_fetch_tb.sv
// self-checking bench for the text fetch block
`timescale 1ns/1ps
module text_display_fetch_tb import tdf_pkg::*;;
    logic        sys_clk = 1'b0, rst_n = 1'b0, slow = 1'b0, pix_ready = 1'b0;
    logic        host_sel = 1'b0, host_rs = 1'b0, host_we = 1'b0, rec = 1'b0, arm = 1'b0;
    logic [7:0]  host_wdata = 8'h00, host_rdata, ram_rdata, pix_data, rv;
    logic [15:0] def_base = 16'h2000, ram_addr, want = 16'h0000;
    logic        ram_req_valid, ram_req_ready, ram_rvalid, pix_valid, hsync, vsync, disp_en;
    logic [4:0]  cyc = 5'h00;            // consumer stall pacing
    logic [1:0]  seen = 2'b00;           // hsync and disp_en ever high
    logic [15:0] aq[$];                  // accepted ram addresses
    logic [7:0]  pq[$];                  // taken pattern bytes
    int          n_errors = 0, num_checks = 0, vs_n = 0, both_n = 0;
    // small frame: 8 cells by 4 rows, 4 by 2 visible
    logic [5:0]  gi[10] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h17, 6'h08};
    logic [7:0]  gv[10] = '{8'h07, 8'h04, 8'h05, 8'h11, 8'h03, 8'h02, 8'h02, 8'h02, 8'h1F, 8'hFF};
    // defaults: index and expected value
    logic [5:0]  di[9]  = '{6'h01, 6'h06, 6'h09, 6'h0C, 6'h0D, 6'h16, 6'h17, 6'h24, 6'h08};
    logic [7:0]  dv[9]  = '{8'h50, 8'h19, 8'h07, 8'h00, 8'h00, 8'h78, 8'h08, 8'h05, 8'h00};

    tdf_text_fetch u_tdf_text_fetch (.sys_clk(sys_clk), .rst_n(rst_n), .host_sel(host_sel), .host_rs(host_rs),
        .host_we(host_we), .host_wdata(host_wdata), .host_rdata(host_rdata), .def_base(def_base),
        .ram_req_valid(ram_req_valid), .ram_req_ready(ram_req_ready), .ram_addr(ram_addr),
        .ram_rvalid(ram_rvalid), .ram_rdata(ram_rdata), .pix_valid(pix_valid), .pix_ready(pix_ready),
        .pix_data(pix_data), .hsync(hsync), .vsync(vsync), .disp_en(disp_en));
    tdf_ram_model u_tdf_ram_model (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .ram_req_valid(ram_req_valid),
        .ram_req_ready(ram_req_ready), .ram_addr(ram_addr), .ram_rvalid(ram_rvalid), .ram_rdata(ram_rdata));

    always #10 sys_clk = ~sys_clk;
    // consumer stalls 24 of every 32 cycles so the buffer fills
    always @(posedge sys_clk) begin
        cyc       <= cyc + 5'h01;
        pix_ready <= ~(cyc[4] | cyc[3]);
    end
    // log transfers from the armed frame start on; watch sync placement
    always @(posedge sys_clk) begin
        if (ram_req_valid && ram_req_ready) begin
            if (arm && ram_addr === want)
                rec = 1'b1;
            if (rec)
                aq.push_back(ram_addr);
        end
        if (rec && pix_valid && pix_ready)
            pq.push_back(pix_data);
        if (rst_n && vsync === 1'b1)
            vs_n++;
        if (rst_n && (hsync | vsync) & disp_en)
            both_n++;
        seen = seen | {hsync === 1'b1, disp_en === 1'b1};
    end

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one host access, strobe held for exactly one edge
    task automatic strobe(input logic rs, input logic we, input logic [7:0] wd);
        @(posedge sys_clk);
        host_sel   <= 1'b1;
        host_rs    <= rs;
        host_we    <= we;
        host_wdata <= wd;
        @(posedge sys_clk);
        host_sel <= 1'b0;
        @(negedge sys_clk);
    endtask
    // index write, then poll status until ready
    task automatic select(input logic [5:0] idx);
        logic [7:0] st;
        strobe(1'b0, 1'b1, {2'b00, idx});
        st = 8'h00;
        for (int i = 0; i < 4 && st[7] !== 1'b1; i++) begin
            strobe(1'b0, 1'b0, 8'h00);
            st = host_rdata;
        end
        chk8("status", {2'b10, idx}, st);
    endtask
    task automatic reg_wr(input logic [5:0] idx, input logic [7:0] v);
        select(idx);
        strobe(1'b1, 1'b1, v);
    endtask
    task automatic reg_rd(input logic [5:0] idx, output logic [7:0] v);
        select(idx);
        strobe(1'b1, 1'b0, 8'h00);
        v = host_rdata;
    endtask
    // program one frame and compare its whole fetch and pattern order
    task automatic run_frame(input logic [15:0] st, input logic [7:0] cvt, input logic [7:0] chg,
                             input logic [15:0] base, input logic sl);
        int lines, bpc, k;
        logic [15:0] a, d;
        logic [7:0]  mask;
        lines = int'(cvt[4:0]) + 1;
        bpc   = (cvt[4:0] >= 5'h10) ? 32 : 16;
        mask  = (chg[3:0] >= 4'h8) ? 8'hFF : ~(8'hFF >> chg[3:0]);
        reg_wr(6'h09, cvt);
        reg_wr(6'h16, chg);
        reg_wr(6'h0C, st[15:8]);
        reg_wr(6'h0D, st[7:0]);
        @(posedge sys_clk);
        slow     <= sl;
        def_base <= base;
        aq.delete();
        pq.delete();
        want = st;
        arm  = 1'b1;
        for (k = 0; k < 40000 && (aq.size() < 16 * lines || pq.size() < 8 * lines); k++)
            @(posedge sys_clk);
        arm = 1'b0;
        rec = 1'b0;
        k   = 0;
        for (int r = 0; r < 2; r++)
            for (int s = 0; s < lines; s++)
                for (int c = 0; c < 4; c++) begin
                    a = st + 16'(r * 4 + c);
                    d = base + 16'(int'(a[7:0]) * bpc + s);
                    chk16("code_addr", a, aq[2*k]);
                    chk16("def_addr", d, aq[2*k+1]);
                    chk8("pattern", d[7:0] & mask, pq[k]);
                    k++;
                end
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // watchdog, well beyond the expected run
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_errors++;
        wrap_up;
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            reg_rd(di[i], rv);
            chk8("reset_value", dv[i], rv);
        end
        for (int i = 0; i < 10; i++)
            reg_wr(gi[i], gv[i]);
        for (int i = 0; i < 10; i++) begin
            reg_rd(gi[i], rv);
            chk8("readback", (gi[i] == 6'h08) ? 8'h00 : gv[i], rv);
        end
        run_frame(16'h1200, 8'h07, 8'h78, 16'h2000, 1'b0);
        run_frame(16'h13FE, 8'h11, 8'h76, 16'h3000, 1'b1);
        chk8("vsync_seen", 8'h01, {7'h00, vs_n > 0});
        chk8("sync_in_view", 8'h00, {7'h00, both_n != 0});
        chk8("hs_de_seen", 8'h03, {6'h00, seen});
        wrap_up;
    end
endmodule // text_display_fetch_tb
